// ### design/nvm_ctrl.sv
// Register access over APB and the register addresses were decided locally.
module nvm_ctrl
  import nvm_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = TMO_CYC  // response timeout in pclk cycles
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial eeprom pins
  output logic             nvm_cs,
  output logic             serial_clock_pin,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe_n,
  input  wire logic        serial_data_pin_in,
  // media monitor sources for the pins
  input  wire logic        media_mon_data,
  input  wire logic        media_mon_clk
);

  // whole controller state
  typedef struct packed {
    nvm_state_e         st;       // sequencer state
    logic               busy;     // op_pending_bit
    logic [2:0]         opc;      // op_code_field
    logic [LOC_W-1:0]   loc;      // location_field
    logic               tmo;      // response_timeout_flag
    logic               loaded;   // addr_loaded_flag
    logic [7:0]         data;     // nvm_data_register
    logic [47:0]        sa;       // station address
    logic [3:0]         pcfg;     // pin configuration
    logic               ld;       // address load in progress
    logic [2:0]         ldi;      // load step
    logic [4:0]         bitc;     // frame bits left
    logic               lng;      // long frame
    logic               rd_op;    // frame returns data
    logic               poll_op;  // frame needs ready poll
    logic [FRAME_W-1:0] sh;       // outgoing frame
    logic [7:0]         rx;       // incoming byte
    logic [7:0]         div;      // half period counter
    logic               sk;       // serial clock
    logic               cs;       // chip select
    logic               dout;     // serial data out
    logic               doe_n;    // data driven when low
    logic [TCNT_W-1:0]  tcnt;     // response timer
    logic [4:0]         ec;       // serial clock rises in frame
    logic [31:0]        prdata;   // apb read data
    logic               pready;   // apb ready
    logic               pslverr;  // apb error
    logic               pin_c;    // clock pin
    logic               pin_d;    // data pin
    logic               pin_oe_n; // data pin enable
    logic               pin_cs;   // chip select pin
  } nvm_q_s;

  // reset image: boot load starts at once
  localparam nvm_q_s RST_Q = '{
    st:       ST_IDLE,
    busy:     1'b1,
    ld:       1'b1,
    doe_n:    1'b1,
    pin_oe_n: 1'b1,
    default:  '0
  };

  nvm_q_s q;        // registered state
  nvm_q_s next_q;   // next state
  logic   din;      // synchronised data pin
  logic   fin;      // operation ends this cycle
  logic   tmo_hit;  // response timer expired
  logic   go;       // host start accepted
  logic   wr;       // apb write takes effect

  // data pin crosses into pclk domain
  nvm_sync u_din_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (serial_data_pin_in),
    .q     (din)
  );

  // address hit test
  function automatic logic reg_hit(input logic [7:0] a);
    return (a == OFS_CMD) || (a == OFS_DATA) || (a == OFS_SAL) || (a == OFS_SAH) || (a == OFS_PIN);
  endfunction

  // next-state logic
  always_comb begin
    logic [2:0]  op;
    logic [31:0] v;
    op      = OP_READ;
    v       = '0;
    next_q  = q;
    fin     = 1'b0;
    tmo_hit = 1'b0;
    go      = 1'b0;
    wr      = psel && penable && q.pready && pwrite;

    // apb setup phase: answer in the first access cycle
    next_q.pready  = 1'b0;
    next_q.pslverr = 1'b0;
    if (psel && !penable) begin
      next_q.pready  = 1'b1;
      next_q.pslverr = !reg_hit(paddr);
      case (paddr)
        OFS_CMD: begin
          v[CMD_BUSY]                  = q.busy;
          v[CMD_OP_MSB:CMD_OP_LSB]     = q.opc;
          v[CMD_TMO]                   = q.tmo;
          v[CMD_LD]                    = q.loaded;
          v[LOC_W-1:0]                 = q.loc;
        end
        OFS_DATA: v[7:0]  = q.data;
        OFS_SAL:  v       = q.sa[31:0];
        OFS_SAH:  v[15:0] = q.sa[47:32];
        OFS_PIN:  v[3:0]  = q.pcfg;
        default:  v       = '0;   // unmapped reads zero
      endcase
      next_q.prdata = v;
    end

    // apb write at the completing edge
    if (wr) begin
      case (paddr)
        OFS_CMD: begin
          // timeout flag clears on a one
          if (pwdata[CMD_TMO]) begin
            next_q.tmo = 1'b0;
          end
          // command fields frozen while busy
          if (!q.busy) begin
            next_q.opc = pwdata[CMD_OP_MSB:CMD_OP_LSB];
            next_q.loc = pwdata[LOC_W-1:0];
            if (pwdata[CMD_BUSY]) begin
              go          = 1'b1;
              next_q.busy = 1'b1;
              if (pwdata[CMD_OP_MSB:CMD_OP_LSB] == OP_RELOAD) begin
                next_q.ld     = 1'b1;
                next_q.ldi    = LD_SIG;
                next_q.loaded = 1'b0;
              end
            end
          end
        end
        OFS_DATA: begin
          // data is held while an op runs
          if (!q.busy) begin
            next_q.data = pwdata[7:0];
          end
        end
        OFS_SAL: next_q.sa[31:0]  = pwdata;
        OFS_SAH: next_q.sa[47:32] = pwdata[15:0];
        OFS_PIN: next_q.pcfg      = pwdata[3:0];
        default: ;   // unmapped writes ignored
      endcase
    end

    // serial sequencer
    unique case (q.st)
      ST_IDLE: begin
        // launch a host op or the next load read
        if (q.busy) begin
          op             = q.ld ? OP_READ : q.opc;
          next_q.sh      = frame_f(op, q.ld ? {4'h0, q.ldi} : q.loc, q.data);
          next_q.lng     = op_long(op);
          next_q.bitc    = op_long(op) ? FRAME_LONG : FRAME_SHORT;
          next_q.rd_op   = (op == OP_READ);
          next_q.poll_op = op_polls(op);
          next_q.st      = ST_SHIFT;
          next_q.cs      = 1'b1;
          next_q.sk      = 1'b0;
          next_q.dout    = START_BIT;
          next_q.doe_n   = 1'b0;
          next_q.div     = SK_HALF - 8'h01;
          next_q.tcnt    = '0;
          next_q.ec      = '0;
          next_q.rx      = '0;
        end
      end
      ST_SHIFT: begin
        if (q.div != 8'h00) begin
          next_q.div = q.div - 8'h01;
        end else begin
          next_q.div = SK_HALF - 8'h01;
          if (!q.sk) begin
            // rising edge
            next_q.sk = 1'b1;
            next_q.ec = q.ec + 5'h01;
          end else begin
            // falling edge: sample data, present next bit
            next_q.sk = 1'b0;
            if (q.rd_op && (q.bitc <= DATA_BITS)) begin
              next_q.rx = {q.rx[6:0], din};
            end
            next_q.sh   = {q.sh[FRAME_W-2:0], 1'b0};
            next_q.dout = q.sh[FRAME_W-2];
            next_q.bitc = q.bitc - 5'h01;
            // let the device drive its data bits
            if (q.rd_op && ((q.bitc - 5'h01) <= DATA_BITS)) begin
              next_q.doe_n = 1'b1;
            end
            // frame done: drop select briefly
            if (q.bitc == BIT_LAST) begin
              next_q.st    = ST_GAP;
              next_q.cs    = 1'b0;
              next_q.doe_n = 1'b1;
            end
          end
        end
      end
      ST_GAP: begin
        // select low for one half period
        if (q.div != 8'h00) begin
          next_q.div = q.div - 8'h01;
        end else if (q.poll_op) begin
          next_q.st  = ST_POLL;
          next_q.cs  = 1'b1;
          // settle time before polling, so the synchroniser drops the released gap level
          next_q.div = SK_HALF - 8'h01;
        end else begin
          fin = 1'b1;
        end
      end
      ST_POLL: begin
        // din still shows the released gap level for the first two settle cycles, while the synchroniser catches up
        if (q.div != 8'h00) begin
          next_q.div = q.div - 8'h01;
        end else if (din) begin
          // device pulls data high when ready
          fin = 1'b1;
        end
      end
    endcase

    // response timer runs from op start
    if (q.st != ST_IDLE) begin
      if (q.tcnt == TCNT_W'(TMO_CYCLES - 1)) begin
        tmo_hit    = 1'b1;
        fin        = 1'b1;
        next_q.tmo = 1'b1;
      end else begin
        next_q.tcnt = q.tcnt + {{(TCNT_W-1){1'b0}}, 1'b1};
      end
    end

    // end of operation
    if (fin) begin
      next_q.st    = ST_IDLE;
      next_q.cs    = 1'b0;
      next_q.sk    = 1'b0;
      next_q.doe_n = 1'b1;
      if (q.ld && !tmo_hit) begin
        if (q.ldi == LD_SIG) begin
          if (q.rx != SIG) begin
            // no signature: leave address and flag
            next_q.ld   = 1'b0;
            next_q.busy = 1'b0;
          end else begin
            next_q.ldi = q.ldi + 3'h1;
          end
        end else begin
          next_q.sa[(int'(q.ldi) - 1) * 8 +: 8] = q.rx;
          if (q.ldi == SA_BYTES) begin
            next_q.loaded = 1'b1;
            next_q.ld     = 1'b0;
            next_q.busy   = 1'b0;
          end else begin
            next_q.ldi = q.ldi + 3'h1;
          end
        end
      end else begin
        next_q.ld   = 1'b0;
        next_q.busy = 1'b0;
        if (!q.ld && q.rd_op && !tmo_hit) begin
          next_q.data = q.rx;
        end
      end
    end

    // pin multiplexer
    if (q.pcfg[PIN_DIS]) begin
      next_q.pin_c    = q.pcfg[PIN_MON] ? media_mon_clk : q.pcfg[PIN_GC];
      next_q.pin_d    = q.pcfg[PIN_MON] ? media_mon_data : q.pcfg[PIN_GD];
      next_q.pin_oe_n = 1'b0;
      next_q.pin_cs   = 1'b0;
    end else begin
      next_q.pin_c    = next_q.sk;
      next_q.pin_d    = next_q.dout;
      next_q.pin_oe_n = next_q.doe_n;
      next_q.pin_cs   = next_q.cs;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST_Q;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flops
  assign prdata               = q.prdata;
  assign pready               = q.pready;
  assign pslverr              = q.pslverr;
  assign nvm_cs               = q.pin_cs;
  assign serial_clock_pin     = q.pin_c;
  assign serial_data_pin_out  = q.pin_d;
  assign serial_data_pin_oe_n = q.pin_oe_n;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_frame_end;
    (q.st == ST_SHIFT) ##1 (q.st == ST_GAP);
  endsequence

  sequence s_load_ok;
    fin && q.ld && !tmo_hit;
  endsequence

  property p_sig_loc;
    (q.st == ST_IDLE && q.busy && q.ld && q.ldi == LD_SIG) |=> (q.sh[FR_A_MSB:FR_A_LSB] == SIG_LOC);
  endproperty
  a_sig_loc: assert property (p_sig_loc) else $error("signature read not at location zero");

  property p_sa_byte;
    (s_load_ok and (q.ldi != LD_SIG)) |=> (q.sa[(int'($past(q.ldi)) - 1) * 8 +: 8] == $past(q.rx));
  endproperty
  a_sa_byte: assert property (p_sa_byte) else $error("station address byte misplaced");

  property p_loaded;
    (s_load_ok and (q.ldi == SA_BYTES)) |=> (q.loaded && !q.busy);
  endproperty
  a_loaded: assert property (p_loaded) else $error("loaded flag not set after sixth byte");

  property p_sig_bad;
    (s_load_ok and (q.ldi == LD_SIG) and (q.rx != SIG)) |=> (!q.loaded && !q.busy && $stable(q.sa));
  endproperty
  a_sig_bad: assert property (p_sig_bad) else $error("signature mismatch changed state");

  property p_reload;
    (go && pwdata[CMD_OP_MSB:CMD_OP_LSB] == OP_RELOAD) |=> (q.ld && !q.loaded && q.ldi == LD_SIG);
  endproperty
  a_reload: assert property (p_reload) else $error("reload did not restart the load");

  property p_busy_clr;
    (fin && !q.ld) |=> (!q.busy && q.st == ST_IDLE);
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared at op end");

  property p_rd_data;
    (fin && !q.ld && q.rd_op && !tmo_hit) |=> (q.data == $past(q.rx));
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read byte not in data register");

  property p_timeout;
    (q.st != ST_IDLE && q.tcnt == TCNT_W'(TMO_CYCLES - 1)) |=> (q.tmo && q.st == ST_IDLE && !q.cs);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  property p_clk_count;
    s_frame_end |-> (q.ec == (q.lng ? FRAME_LONG : FRAME_SHORT));
  endproperty
  a_clk_count: assert property (p_clk_count) else $error("wrong serial clock count");

  property p_gpo;
    (q.pcfg[PIN_DIS] && !q.pcfg[PIN_MON]) |=> (serial_clock_pin == $past(q.pcfg[PIN_GC]) && !serial_data_pin_oe_n);
  endproperty
  a_gpo: assert property (p_gpo) else $error("disabled pins not general outputs");

  property p_cs_frame;
    (q.st == ST_SHIFT && q.sk) |-> q.cs;
  endproperty
  a_cs_frame: assert property (p_cs_frame) else $error("clock pulse without select");

  property p_poll;
    (q.st == ST_POLL && q.div == 8'h00 && din && !tmo_hit) |=> (q.st == ST_IDLE && !q.cs);
  endproperty
  a_poll: assert property (p_poll) else $error("ready indication not taken");

  property p_poll_settle;
    (q.st == ST_POLL && q.div != 8'h00 && !tmo_hit) |=> (q.st == ST_POLL && q.cs);
  endproperty
  a_poll_settle: assert property (p_poll_settle) else $error("poll ended before settling");

endmodule // nvm_ctrl

// ### design/nvm_pkg.sv
// Contract
// - read location zero after any reset
// - signature match loads six address bytes
// - set address-loaded flag after sixth byte
// - signature mismatch leaves address and flag
// - reload command repeats the signature check
// - busy set starts op, cleared when done
// - read byte lands in data register
// - 30 ms without response sets timeout
// - erase clears the addressed location
// - erase-all clears the whole array
// - read fetches the addressed location
// - write stores data at addressed location
// - write-all stores data everywhere
// - 10 clocks short ops, 18 long
// - array is 128 byte locations
// - disabled interface turns pins into outputs
package nvm_pkg;

  // timing
  localparam int unsigned CLK_NS     = 5;         // pclk period
  localparam int unsigned SK_HALF_NS = 500;       // serial clock half period
  localparam int unsigned TMO_MS     = 30;        // response timeout
  localparam int unsigned NS_PER_MS  = 1000000;
  localparam logic [7:0]  SK_HALF    = 8'((SK_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned TMO_CYC    = TMO_MS * NS_PER_MS / CLK_NS;
  localparam int unsigned TCNT_W     = 23;        // timeout counter width

  // apb register byte offsets
  localparam logic [7:0] OFS_CMD  = 8'h00;        // nvm_command_register
  localparam logic [7:0] OFS_DATA = 8'h04;        // nvm_data_register
  localparam logic [7:0] OFS_SAL  = 8'h08;        // station_addr_low
  localparam logic [7:0] OFS_SAH  = 8'h0C;        // station_addr_high
  localparam logic [7:0] OFS_PIN  = 8'h10;        // pin configuration

  // command register fields
  localparam int CMD_BUSY   = 31;                 // op_pending_bit
  localparam int CMD_OP_MSB = 30;                 // op_code_field
  localparam int CMD_OP_LSB = 28;
  localparam int CMD_TMO    = 9;                  // response_timeout_flag
  localparam int CMD_LD     = 8;                  // addr_loaded_flag
  localparam int LOC_W      = 7;                  // location_field width

  // pin configuration fields
  localparam int PIN_DIS = 0;                     // interface disabled
  localparam int PIN_MON = 1;                     // pins show media monitors
  localparam int PIN_GD  = 2;                     // general output, data pin
  localparam int PIN_GC  = 3;                     // general output, clock pin

  // host operation codes
  localparam logic [2:0] OP_READ       = 3'h0;
  localparam logic [2:0] OP_EW_DIS     = 3'h1;
  localparam logic [2:0] OP_EW_EN      = 3'h2;
  localparam logic [2:0] OP_WRITE      = 3'h3;
  localparam logic [2:0] OP_WRITE_ALL  = 3'h4;
  localparam logic [2:0] OP_ERASE      = 3'h5;
  localparam logic [2:0] OP_ERASE_ALL  = 3'h6;
  localparam logic [2:0] OP_RELOAD     = 3'h7;

  // serial frame layout and codes
  localparam int         FRAME_W   = 18;
  localparam int         FR_A_MSB  = 14;          // address bits in frame
  localparam int         FR_A_LSB  = 8;
  localparam logic [0:0] START_BIT = 1'h1;
  localparam logic [1:0] SO_READ   = 2'h2;
  localparam logic [1:0] SO_WRITE  = 2'h1;
  localparam logic [1:0] SO_ERASE  = 2'h3;
  localparam logic [1:0] SO_EXT    = 2'h0;        // extended opcode group
  localparam logic [6:0] EX_EW_DIS = 7'h00;
  localparam logic [6:0] EX_WR_ALL = 7'h20;
  localparam logic [6:0] EX_ER_ALL = 7'h40;
  localparam logic [6:0] EX_EW_EN  = 7'h60;
  localparam logic [7:0] NO_DATA   = 8'h00;
  localparam logic [4:0] FRAME_LONG  = 5'h12;     // 18 clocks
  localparam logic [4:0] FRAME_SHORT = 5'h0A;     // 10 clocks
  localparam logic [4:0] DATA_BITS   = 5'h08;
  localparam logic [4:0] BIT_LAST    = 5'h01;

  // address auto-load
  localparam logic [7:0] SIG      = 8'hA5;        // presence signature
  localparam logic [6:0] SIG_LOC  = 7'h00;
  localparam logic [2:0] LD_SIG   = 3'h0;         // load step reading signature
  localparam logic [2:0] SA_BYTES = 3'h6;

  // controller states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SHIFT = 4'h2,
    ST_GAP   = 4'h4,
    ST_POLL  = 4'h8
  } nvm_state_e;

  // operation uses the 18-clock frame
  function automatic logic op_long(input logic [2:0] op);
    return (op == OP_READ) || (op == OP_WRITE) || (op == OP_WRITE_ALL);
  endfunction

  // operation programs the array and must be polled
  function automatic logic op_polls(input logic [2:0] op);
    return (op == OP_WRITE) || (op == OP_WRITE_ALL) || (op == OP_ERASE) || (op == OP_ERASE_ALL);
  endfunction

  // left-aligned serial frame, msb first
  function automatic logic [FRAME_W-1:0] frame_f(input logic [2:0] op, input logic [6:0] loc,
                                                  input logic [7:0] d);
    logic [FRAME_W-1:0] f;
    f = '0;
    case (op)
      OP_READ:      f = {START_BIT, SO_READ, loc, NO_DATA};
      OP_WRITE:     f = {START_BIT, SO_WRITE, loc, d};
      OP_ERASE:     f = {START_BIT, SO_ERASE, loc, NO_DATA};
      OP_ERASE_ALL: f = {START_BIT, SO_EXT, EX_ER_ALL, NO_DATA};
      OP_WRITE_ALL: f = {START_BIT, SO_EXT, EX_WR_ALL, d};
      OP_EW_EN:     f = {START_BIT, SO_EXT, EX_EW_EN, NO_DATA};
      OP_EW_DIS:    f = {START_BIT, SO_EXT, EX_EW_DIS, NO_DATA};
      default:      f = '0;
    endcase
    return f;
  endfunction

endpackage

// ### design/nvm_sync.sv
module nvm_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level from outside, and its synchronised copy
  input  wire logic d,
  output logic      q
);

  logic [1:0] r;  // r[0] is read only by r[1]

  // two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= 2'h0;
    end else begin
      r <= {r[0], d};
    end
  end

  assign q = r[1];

endmodule // nvm_sync

// ### verif/nvm_eeprom_model.sv
// behavioural 128 x 8 three-wire serial memory on the far side of the controller
module nvm_eeprom_model (
  // pins from the controller
  input  wire logic cs,
  input  wire logic sk,
  input  wire logic di,
  input  wire logic di_oe_n,
  // bench control: never report ready
  input  wire logic mute,
  // resolved data wire level
  output logic      dio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [128];                    // array, 128 locations
  logic [17:0] sr;                           // incoming bits, msb first
  int          n;                            // clocks seen in this frame
  logic        we, pend, drv, dq, rd, lastv; // state and drive of the data line
  logic [6:0]  ra, a;
  logic [1:0]  o;
  logic [7:0]  d;
  initial begin
    we = 0; pend = 0; drv = 0; dq = 0; rd = 0; n = 0; lastv = 0; sr = '0; ra = '0;
    foreach (mem[i]) mem[i] = 8'(8'h10 + i);
    mem[0] = 8'hA5;
  end
  // released line shows the inverse of its last level, so stale data never looks valid
  always @(di or dq or di_oe_n or drv) begin
    if (!di_oe_n) lastv = di;
    else if (drv) lastv = dq;
  end
  assign dio = !di_oe_n ? di : (drv ? dq : ~lastv);
  // shift on the rising serial clock; a read drives its data from clock 11 on
  always @(posedge sk) begin
    if (cs) begin
      sr = {sr[16:0], dio};
      n++;
      if (n == 10 && sr[8:7] == 2'h2) begin
        rd = 1;
        ra = sr[6:0];
      end
      if (rd && n >= 11 && n <= 18) begin
        drv = 1;
        dq  = mem[ra][18-n];
      end
    end
  end
  // decode the frame when select drops; a poll frame only ends the busy phase
  always @(negedge cs) begin
    if (pend) pend = 0;
    else if (n >= 10 && !rd) begin
      if (n == 18) begin o = sr[16:15]; a = sr[14:8]; d = sr[7:0]; end
      else begin o = sr[8:7]; a = sr[6:0]; d = 8'hFF; end
      if (o == 2'h0 && a[6:5] == 2'h3) we = 1;
      if (o == 2'h0 && a[6:5] == 2'h0) we = 0;
      if (we && o == 2'h1) mem[a] = d;
      if (we && o == 2'h3) mem[a] = 8'hFF;
      if (we && o == 2'h0 && a[6:5] != 2'h0 && a[6:5] != 2'h3) foreach (mem[i]) mem[i] = d;
      pend = we && (o != 2'h0 || a[6:5] == 2'h1 || a[6:5] == 2'h2);
    end
    n = 0; rd = 0; drv = 0;
  end
  // busy low on the line, then ready high unless muted
  always @(posedge cs) begin
    if (pend) begin
      drv = 1;
      dq  = 0;
      if (!mute) begin #2000; dq = 1; end
    end
  end
endmodule // nvm_eeprom_model

// ### verif/nvm_ctrl_tb.sv
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", nm, e, s); end end
module nvm_ctrl_tb;
  import nvm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mute = 0, mon_d = 0, mon_c = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, cmd, r;
  logic pready, pslverr, cs, sk, dout, oe_n, dio, err;
  int fail_count = 0, num_checks = 0, clks = 0, lastclk = 0;
  always #2.5 pclk = ~pclk;
  // count serial clocks of each frame that had any
  always @(posedge sk) clks++;
  always @(negedge cs) if (clks != 0) begin lastclk = clks; clks = 0; end
  nvm_ctrl #(.TMO_CYCLES(6000)) nvm_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_cs(cs), .serial_clock_pin(sk), .serial_data_pin_out(dout), .serial_data_pin_oe_n(oe_n),
    .serial_data_pin_in(dio), .media_mon_data(mon_d), .media_mon_clk(mon_c));
  nvm_eeprom_model nvm_eeprom_model_inst (.cs(cs), .sk(sk), .di(dout), .di_oe_n(oe_n), .mute(mute), .dio(dio));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (i = 0; i < 8 && pready !== 1'b1; i++) @(posedge pclk);
    if (pready !== 1'b1) begin fail_count++; print_verdict(); end
    q = prdata; err = pslverr; psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(0, a, '0, r);
    `CHK(nm, e, r)
  endtask
  // poll busy under a bound
  task automatic wait_idle();
    int i;
    cmd = 32'h80000000;
    for (i = 0; i < 20000 && cmd[CMD_BUSY] !== 1'b0; i++) apb(0, OFS_CMD, '0, cmd);
    if (cmd[CMD_BUSY] !== 1'b0) begin fail_count++; print_verdict(); end
  endtask
  // start one host operation, wait for it and check the frame length
  task automatic op(input logic [2:0] o, input logic [6:0] a, input int nclk);
    apb(1, OFS_CMD, {1'b1, o, 21'h0, a}, r);
    wait_idle();
    if (nclk != 0) `CHK("clocks", nclk, lastclk)
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    wait_idle();
    `CHK("loaded", 1'b1, cmd[CMD_LD])
    chk_rd(OFS_SAL, 32'h14131211, "addr low");
    chk_rd(OFS_SAH, 32'h00001615, "addr high");
    $display("test boot done");
    op(OP_EW_EN, '0, 10);
    apb(1, OFS_DATA, 32'h5A, r);
    op(OP_WRITE, 7'h09, 18);
    op(OP_READ, 7'h09, 18);
    chk_rd(OFS_DATA, 32'h5A, "read back");
    op(OP_ERASE, 7'h09, 10);
    op(OP_READ, 7'h09, 18);
    chk_rd(OFS_DATA, 32'hFF, "erased");
    apb(1, OFS_DATA, 32'h3C, r);
    op(OP_WRITE_ALL, '0, 18);
    op(OP_READ, 7'h7F, 18);
    chk_rd(OFS_DATA, 32'h3C, "write all");
    op(OP_ERASE_ALL, '0, 10);
    op(OP_READ, 7'h40, 18);
    chk_rd(OFS_DATA, 32'hFF, "erase all");
    op(OP_EW_DIS, '0, 10);
    apb(0, 8'h20, '0, r);
    `CHK("unmapped", 1'b1, err)
    `CHK("unmapped data", 32'h0, r)
    $display("test host ops done");
    op(OP_RELOAD, '0, 18);
    `CHK("reload miss", 1'b0, cmd[CMD_LD])
    chk_rd(OFS_SAL, 32'h14131211, "addr kept");
    nvm_eeprom_model_inst.mem[0] = 8'hA5;
    op(OP_RELOAD, '0, 18);
    `CHK("reload hit", 1'b1, cmd[CMD_LD])
    chk_rd(OFS_SAL, 32'hFFFFFFFF, "addr new");
    $display("test reload done");
    op(OP_EW_EN, '0, 10);
    apb(1, OFS_DATA, 32'h5A, r);
    mute <= 1;
    op(OP_WRITE, 7'h01, 18);
    `CHK("timeout", 1'b1, cmd[CMD_TMO])
    apb(1, OFS_CMD, 32'h00000200, r);
    chk_rd(OFS_CMD, 32'h00000100, "timeout clear");
    $display("test timeout done");
    apb(1, OFS_PIN, 32'h0000000D, r);
    repeat (3) @(posedge pclk);
    `CHK("gpo clock", 1'b1, sk)
    `CHK("gpo data", 1'b1, dout)
    `CHK("gpo enable", 1'b0, oe_n)
    mon_c <= 1;
    mon_d <= 1;
    apb(1, OFS_PIN, 32'h00000003, r);
    repeat (3) @(posedge pclk);
    `CHK("mon clock", 1'b1, sk)
    `CHK("mon data", 1'b1, dout)
    $display("test pins done");
    print_verdict();
  end
endmodule // nvm_ctrl_tb
